/* common/dsp_exec_pkg.sv */
package dsp_exec_pkg;

  // -----------------------------------------------------------------------
  // Instruction classes
  // -----------------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP, OP_ILLEGAL, OP_JUMP_ABS, OP_JUMP_REL, OP_LOAD_BYTE,
    OP_LOAD_INDEXED, OP_LOAD_WORD, OP_LOOP, OP_PUSH, OP_RET_INT,
    OP_RET_SUB, OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_XOR_XY, OP_DIV_STEP,
    OP_MAC
  } op_class_e;

  // -----------------------------------------------------------------------
  // Decoded instruction carrier
  // -----------------------------------------------------------------------
  typedef struct packed {
    op_class_e   op;
    logic [3:0]  cond;
    logic [3:0]  dst;
    logic        idx_sel;
    logic [15:0] imm;
    logic [15:0] x_val;
    logic [15:0] y_val;
  } instr_s;

  typedef struct packed {
    logic c;
    logic n;
    logic z;
    logic b;
    logic v;
  } flags_s;

  // -----------------------------------------------------------------------
  // Register map (AXI4-Lite byte offsets)
  // -----------------------------------------------------------------------
  localparam logic [7:0] ADDR_INSTR    = 8'h00;
  localparam logic [7:0] ADDR_IMM      = 8'h04;
  localparam logic [7:0] ADDR_OPERAND  = 8'h08;
  localparam logic [7:0] ADDR_XY       = 8'h0C;
  localparam logic [7:0] ADDR_MEM_DATA = 8'h10;
  localparam logic [7:0] ADDR_PC       = 8'h14;
  localparam logic [7:0] ADDR_ACC      = 8'h18;
  localparam logic [7:0] ADDR_SP_FLAGS = 8'h1C;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;
  localparam logic [7:0] ADDR_MASK     = 8'h24;
  localparam logic [7:0] ADDR_FREG     = 8'h28;
  localparam logic [7:0] ADDR_STORE    = 8'h2C;

  localparam int          ILLEGAL_BIT  = 15;
  localparam int          STATUS_DONE  = 0;
  localparam logic [15:0] SP_RESET     = 16'h00FF;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
  localparam logic [15:0] PC_STEP_ONE  = 16'h0001;
  localparam logic [15:0] PC_STEP_TWO  = 16'h0002;

  localparam logic [3:0]  COND_ALWAYS  = 4'h0;
  localparam logic [3:0]  COND_ZERO    = 4'h1;
  localparam logic [3:0]  COND_NZERO   = 4'h2;
  localparam logic [3:0]  COND_NEG     = 4'h3;
  localparam logic [3:0]  COND_CARRY   = 4'h4;

  // Instruction word at ADDR_INSTR: [4:0] class, [11:8] cond,
  // [15:12] destination, [16] reload select.
  localparam int INSTR_OP_LSB   = 0;
  localparam int INSTR_COND_LSB = 8;
  localparam int INSTR_DST_LSB  = 12;
  localparam int INSTR_IDX_BIT  = 16;

endpackage : dsp_exec_pkg

/* core/dsp_instruction_execute.sv */
// What this block does
// - Illegal opcodes set status bit 15, step PC by one, keep flags.
// - Absolute jump loads the target if true, else PC plus 2, two cycles.
// - Relative jump adds a sign-extended 7-bit offset if true, else PC+1.
// - Byte load sign-extends 8 bits into a fast register, PC plus one.
// - Indexed load reads memory at r3 or r7 plus displacement, PC+1.
// - Word load writes a 16-bit constant to any register, PC plus two.
// - Loop holds PC while its condition is true, then steps PC by one.
// - Push writes a register at SP, then SP minus one and PC plus one.
// - Interrupt return bumps SP then loads PC from stack in three cycles.
// - Subroutine return loads PC from the stack at SP in three cycles.
// - Left shift moves the accumulator left one bit and sets C N Z B.
// - Right shift moves the accumulator right one bit and sets C N Z B.
// - Operand XOR writes X xor Y into the accumulator high half, clears the low half, sets N Z B.
// - Division step subtracts when non-negative and shifts in the bit.
// - Multiply-accumulate adds X times Y to the accumulator, two cycles.
`timescale 1ns/1ps
module dsp_instruction_execute
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Interrupt
  output logic             irq
);
  import dsp_exec_pkg::*;

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef enum {ST_IDLE, ST_EXEC, ST_EXTRA} exec_state_e;

  exec_state_e state;
  instr_s      cur;
  flags_s      flags;

  logic [15:0] pc;
  logic [15:0] stack_pointer;
  logic [15:0] accum_high;
  logic [15:0] accum_low;

  logic [15:0] fast_reg [0:15];
  logic [15:0] mem_data;
  logic [15:0] store_data;

  logic [15:0] status;
  logic [15:0] mask;

  logic [1:0]  cycles;
  logic        loop_active;

  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // -----------------------------------------------------------------------
  // Condition evaluation
  // -----------------------------------------------------------------------
  function automatic logic cond_true(input logic [3:0] c, input flags_s f);
    case (c)
      COND_ALWAYS: cond_true = 1'b1;
      COND_ZERO:   cond_true = f.z;
      COND_NZERO:  cond_true = !f.z;
      COND_NEG:    cond_true = f.n;
      COND_CARRY:  cond_true = f.c;
      default:     cond_true = 1'b0;
    endcase
  endfunction : cond_true

  function automatic flags_s logic_flags(input logic [31:0] a,
                                         input flags_s f);
    logic_flags   = f;
    logic_flags.n = a[31];
    logic_flags.z = (a == 32'h0000_0000);
    logic_flags.b = (a[31:16] != {16{a[15]}});
  endfunction : logic_flags

  // -----------------------------------------------------------------------
  // Datapath
  // -----------------------------------------------------------------------
  wire logic [31:0] accum       = {accum_high, accum_low};
  wire logic        taken       = cond_true(cur.cond, flags);

  wire logic [31:0] shl_val     = {accum[30:0], 1'b0};
  wire logic [31:0] shr_val     = {1'b0, accum[31:1]};
  wire logic [31:0] xor_val     = {cur.x_val ^ cur.y_val, 16'h0000};
  wire logic [16:0] div_diff    = {1'b0, accum_high} - {1'b0, cur.x_val};
  wire logic        div_ok      = !div_diff[16];
  wire logic [31:0] div_val     = div_ok ?
                                  {div_diff[14:0], accum_low, 1'b1} :
                                  {accum[30:0], 1'b0};

  wire logic [31:0] product     = $signed(cur.x_val) * $signed(cur.y_val);
  wire logic [32:0] mac_sum     = {accum[31], accum} +
                                  {product[31], product};

  wire logic [15:0] rel_off     = {{9{cur.imm[6]}}, cur.imm[6:0]};
  wire logic [15:0] byte_val    = {{8{cur.imm[7]}}, cur.imm[7:0]};
  wire logic [15:0] disp_val    = {{8{cur.imm[7]}}, cur.imm[7:0]};
  wire logic [15:0] reload_reg  = cur.idx_sel ? fast_reg[7] : fast_reg[3];
  wire logic [15:0] index_addr  = reload_reg + disp_val;

  wire logic [15:0] pc_one      = pc + PC_STEP_ONE;
  wire logic [15:0] pc_two      = pc + PC_STEP_TWO;

  wire logic [1:0]  need_cycles = (cur.op == OP_RET_INT ||
                                   cur.op == OP_RET_SUB) ? 2'd2 :
                                  (cur.op == OP_JUMP_ABS ||
                                   cur.op == OP_MAC) ? 2'd1 : 2'd0;
  wire logic        finish      = (state == ST_EXEC && need_cycles == 2'd0)
                                  || (state == ST_EXTRA && cycles == 2'd1);

  // -----------------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------------
  wire logic        wr_fire  = aw_held && w_held && !s_axi_bvalid;
  wire logic        wr_instr = wr_fire && aw_addr == ADDR_INSTR;
  wire logic        wr_clear = wr_fire && aw_addr == ADDR_STATUS;
  wire logic        busy     = state != ST_IDLE;
  wire logic        wr_map   = aw_addr <= ADDR_STORE && aw_addr[1:0] == 2'b00;
  wire logic [15:0] clr_bits = wr_clear ? w_data[15:0] : 16'h0000;
  wire logic        done_ev  = finish;
  wire logic        ill_ev   = finish && cur.op == OP_ILLEGAL;
  wire logic [15:0] set_bits = {ill_ev, 14'h0000, done_ev};

  // -----------------------------------------------------------------------
  // Write channel
  // -----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_map && !(wr_instr && busy)) ? RESP_OKAY
                                                        : RESP_SLVERR;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Software-loaded fields and status
  // -----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur        <= '0;
      mem_data   <= 16'h0000;
      mask       <= 16'h0000;
      status     <= 16'h0000;
      irq        <= 1'b0;
    end else begin
      status <= (status & ~clr_bits) | set_bits;
      irq    <= |(((status & ~clr_bits) | set_bits) & mask);
      if (wr_fire && !busy) begin
        case (aw_addr)
          ADDR_INSTR: begin
            cur.op      <= op_class_e'(w_data[INSTR_OP_LSB +: 5]);
            cur.cond    <= w_data[INSTR_COND_LSB +: 4];
            cur.dst     <= w_data[INSTR_DST_LSB +: 4];
            cur.idx_sel <= w_data[INSTR_IDX_BIT];
          end
          ADDR_IMM:      cur.imm   <= w_data[15:0];
          ADDR_OPERAND:  cur.x_val <= w_data[15:0];
          ADDR_XY:       cur.y_val <= w_data[15:0];
          ADDR_MEM_DATA: mem_data  <= w_data[15:0];
          ADDR_MASK:     mask      <= w_data[15:0];
          default: ;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------------
  // Execution engine
  // -----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state         <= ST_IDLE;
      cycles        <= 2'd0;
      pc            <= 16'h0000;
      stack_pointer <= SP_RESET;
      accum_high    <= 16'h0000;
      accum_low     <= 16'h0000;
      flags         <= '0;
      store_data    <= 16'h0000;
      loop_active   <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        fast_reg[i] <= 16'h0000;
      end
    end else begin
      case (state)
        ST_IDLE: begin
          if (wr_instr && !busy) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          cycles <= need_cycles;
          state  <= (need_cycles == 2'd0) ? ST_IDLE : ST_EXTRA;
          case (cur.op)
            OP_ILLEGAL:   pc <= pc_one;
            OP_JUMP_ABS:  pc <= taken ? cur.imm : pc_two;
            OP_JUMP_REL:  pc <= taken ? pc + rel_off : pc_one;
            OP_LOAD_BYTE: begin
              fast_reg[cur.dst] <= byte_val;
              pc                <= pc_one;
            end
            OP_LOAD_INDEXED: begin
              fast_reg[cur.dst] <= mem_data;
              store_data        <= index_addr;
              pc                <= pc_one;
            end
            OP_LOAD_WORD: begin
              fast_reg[cur.dst] <= cur.imm;
              pc                <= pc_two;
            end
            OP_LOOP: begin
              loop_active <= taken;
              pc          <= taken ? pc : pc_one;
            end
            OP_PUSH: begin
              store_data    <= fast_reg[cur.dst];
              stack_pointer <= stack_pointer - PC_STEP_ONE;
              pc            <= pc_one;
            end
            OP_RET_INT:   stack_pointer <= stack_pointer + PC_STEP_ONE;
            OP_SHIFT_LEFT: begin
              {accum_high, accum_low} <= shl_val;
              flags   <= logic_flags(shl_val, flags);
              flags.c <= accum[31];
              pc      <= pc_one;
            end
            OP_SHIFT_RIGHT: begin
              {accum_high, accum_low} <= shr_val;
              flags   <= logic_flags(shr_val, flags);
              flags.c <= accum[0];
              pc      <= pc_one;
            end
            OP_XOR_XY: begin
              {accum_high, accum_low} <= xor_val;
              flags <= logic_flags(xor_val, flags);
              pc    <= pc_one;
            end
            OP_DIV_STEP: begin
              {accum_high, accum_low} <= div_val;
              flags <= logic_flags(div_val, flags);
              pc    <= pc_one;
            end
            OP_MAC:       pc <= pc_one;
            default:      pc <= pc_one;
          endcase
        end
        ST_EXTRA: begin
          cycles <= cycles - 2'd1;
          if (cycles == 2'd1 && cur.op == OP_MAC) begin
            {accum_high, accum_low} <= mac_sum[31:0];
            flags   <= logic_flags(mac_sum[31:0], flags);
            flags.v <= mac_sum[32] != mac_sum[31];
          end
          if (cycles == 2'd1 && (cur.op == OP_RET_INT ||
                                 cur.op == OP_RET_SUB)) begin
            pc <= mem_data;
          end
          if (cycles == 2'd1) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Read channel
  // -----------------------------------------------------------------------
  wire logic [31:0] rd_mux =
    (s_axi_araddr == ADDR_PC)       ? {16'h0000, pc} :
    (s_axi_araddr == ADDR_ACC)      ? accum :
    (s_axi_araddr == ADDR_SP_FLAGS) ? {11'h000, flags, stack_pointer} :
    (s_axi_araddr == ADDR_STATUS)   ? {14'h0000, loop_active, busy, status} :
    (s_axi_araddr == ADDR_MASK)     ? {16'h0000, mask} :
    (s_axi_araddr == ADDR_FREG)     ? {16'h0000, fast_reg[cur.dst]} :
    (s_axi_araddr == ADDR_STORE)    ? {16'h0000, store_data} :
                                      32'h0000_0000;
  wire logic rd_map = s_axi_araddr <= ADDR_STORE &&
                      s_axi_araddr[1:0] == 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : dsp_instruction_execute

/* tb/dsp_instruction_execute_props.sv */
`timescale 1ns/1ps
module dsp_instruction_execute_props
  import dsp_exec_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write channels
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Interrupt
  input wire logic        irq
);
  logic [7:0] rd_addr;
  logic       bad_addr;

  // Address of the read in flight.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr <= s_axi_araddr;
    end
  end
  assign bad_addr = (rd_addr > ADDR_STORE) || (rd_addr[1:0] != 2'b00);

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  awready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  wready_pulse_a: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready longer than one cycle");
  read_latency_a: assert property (s_axi_arvalid && s_axi_arready |->
    ##[1:2] s_axi_rvalid) else $error("read answer late");
  write_latency_a: assert property (s_axi_awvalid && s_axi_awready |->
    ##[1:3] s_axi_bvalid) else $error("write answer late");
  read_cause_a: assert property ($rose(s_axi_rvalid) |->
    $past(s_axi_arvalid) || $past(s_axi_arvalid, 2))
    else $error("rvalid without request");
  slverr_decode_a: assert property (s_axi_rvalid && bad_addr |->
    s_axi_rresp == RESP_SLVERR) else $error("bad address not refused");
  okay_decode_a: assert property (s_axi_rvalid && !bad_addr |->
    s_axi_rresp == RESP_OKAY) else $error("mapped address refused");
  reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !irq) else $error("busy after reset");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  cover property ($rose(irq));
endmodule : dsp_instruction_execute_props

bind dsp_instruction_execute dsp_instruction_execute_props u_props (.*);

/* tb/dsp_memory_model.sv */
`timescale 1ns/1ps
module dsp_memory_model (
  // Clock
  input wire logic        clk,
  // Access
  input wire logic        we,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  output logic [15:0]     rdata
);
  logic [15:0] mem [256];

  // A per-address pattern keeps a stale word from passing.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'hA5C3 ^ 16'(i * 257);
    end
  end
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end
  assign rdata = mem[addr];
endmodule : dsp_memory_model

/* tb/tb_dsp_instruction_execute.sv */
`timescale 1ns/1ps
module tb_dsp_instruction_execute;
  import dsp_exec_pkg::*;
  logic aclk = 1'b0, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, mm_we, cy;
  logic [7:0]  awaddr, araddr, mm_addr;
  logic [31:0] wdata, rdata, acc, got;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] pc, sp, x, y, v, mm_wdata, mm_rdata;
  logic [4:0]  fl;
  logic [31:0] seed = 32'd66430;
  int miscompares, compares;

  always #2.5 aclk = ~aclk;

  dsp_instruction_execute u_dut (
    .aclk(aclk), .aresetn(aresetn), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  dsp_memory_model u_mem (
    .clk(aclk), .we(mm_we), .addr(mm_addr), .wdata(mm_wdata),
    .rdata(mm_rdata)
  );

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic ctrue(input logic [3:0] c);
    case (c)
      COND_ALWAYS: return 1'b1;
      COND_ZERO:   return fl[2];
      COND_NZERO:  return !fl[2];
      COND_NEG:    return fl[3];
      COND_CARRY:  return fl[4];
      default:     return 1'b0;
    endcase
  endfunction : ctrue
  function automatic logic [4:0] fl_of(input logic [31:0] a, input logic c);
    return {c, a[31], a == 32'h0000_0000, fl[1:0]};
  endfunction : fl_of
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_resp(input string nm, input logic [1:0] e, g);
    chk(nm, 32'(e), 32'(g));
  endtask : chk_resp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    if (n >= 40) miscompares++;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    if (n >= 40) miscompares++;
    d = rdata;
    r = rresp;
  endtask : rd
  task automatic rc(input logic [7:0] a, input string nm,
                    input logic [31:0] e, m);
    rd(a, got, resp);
    chk(nm, e & m, got & m);
  endtask : rc
  task automatic st();
    rc(ADDR_PC, "program counter", {16'h0000, pc}, 32'h0000_FFFF);
    rc(ADDR_SP_FLAGS, "flags and stack", {11'h000, fl, sp}, 32'h001C_FFFF);
  endtask : st
  task automatic ex(input op_class_e op, input logic [3:0] c, d,
                    input logic ix);
    int n;
    n = 0;
    wr(ADDR_STATUS, 32'h0000_0001);
    wr(ADDR_INSTR, {15'h0000, ix, d, c, 3'b000, op});
    do begin
      rd(ADDR_STATUS, got, resp);
      n++;
    end while ((got[16] || !got[STATUS_DONE]) && n < 20);
    if (n >= 20) miscompares++;
  endtask : ex
  task automatic mem_fetch(input logic [7:0] a);
    mm_addr <= a;
    @(posedge aclk);
    wr(ADDR_MEM_DATA, {16'h0000, mm_rdata});
  endtask : mem_fetch
  task automatic sweep();
    logic [6:0] o;
    for (int k = 0; k < 6; k++) begin
      o = (k == 0) ? 7'h40 : (k == 1) ? 7'h3F : 7'(rnd());
      wr(ADDR_IMM, {25'h000_0000, o});
      ex(OP_JUMP_REL, 4'(k), 4'h0, 1'b0);
      pc = ctrue(4'(k)) ? pc + {{9{o[6]}}, o} : pc + PC_STEP_ONE;
      st();
      v = 16'(rnd());
      wr(ADDR_IMM, {16'h0000, v});
      ex(OP_JUMP_ABS, 4'(k), 4'h0, 1'b0);
      pc = ctrue(4'(k)) ? v : pc + PC_STEP_TWO;
      st();
    end
  endtask : sweep
  task automatic acc_op(input op_class_e op);
    ex(op, 4'h0, 4'h0, 1'b0);
    pc = pc + PC_STEP_ONE;
    rc(ADDR_ACC, "accumulator", acc, 32'hFFFF_FFFF);
  endtask : acc_op
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (30000) @(posedge aclk);
    miscompares++;
    stop_test();
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, arvalid, mm_we} = 5'b00000;
    {awaddr, araddr, mm_addr, wdata, mm_wdata} = '0;
    {bready, rready, wstrb} = 6'b11_1111;
    {miscompares, compares, pc, acc, fl, sp} = {64'h0, 53'h0, SP_RESET};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    st();
    rd(8'h30, got, resp);
    chk_resp("unmapped read", RESP_SLVERR, resp);
    rd(8'h06, got, resp);
    chk_resp("unaligned read", RESP_SLVERR, resp);
    $display("test reset done");
    wr(ADDR_MASK, 32'h0000_8000);
    ex(OP_ILLEGAL, 4'h0, 4'h0, 1'b0);
    pc = pc + PC_STEP_ONE;
    st();
    x = 16'(rnd());
    wr(ADDR_OPERAND, {16'h0000, x});
    wr(ADDR_XY, {16'h0000, x});
    acc = 32'h0000_0000;
    fl = fl_of(acc, fl[4]);
    acc_op(OP_XOR_XY);
    sweep();
    rc(ADDR_STATUS, "illegal flag", 32'h0000_8000, 32'h0000_8000);
    chk("interrupt", 32'h1, {31'h0, irq});
    wr(ADDR_MASK, 32'h0000_0000);
    rd(ADDR_MASK, got, resp);
    chk("masked interrupt", 32'h0, {31'h0, irq});
    wr(ADDR_MASK, 32'h0000_8000);
    wr(ADDR_STATUS, 32'h0000_8000);
    rc(ADDR_STATUS, "cleared flag", 32'h0000_0000, 32'h0000_8000);
    chk("cleared interrupt", 32'h0, {31'h0, irq});
    $display("test illegal done");
    for (int i = 0; i < 3; i++) begin
      {x, y} = rnd();
      wr(ADDR_OPERAND, {16'h0000, x});
      wr(ADDR_XY, {16'h0000, y});
      acc = {x ^ y, 16'h0000};
      fl = fl_of(acc, fl[4]);
      acc_op(OP_XOR_XY);
      st();
      cy = acc[31];
      acc = acc << 1;
      fl = fl_of(acc, cy);
      acc_op(OP_SHIFT_LEFT);
      st();
      cy = acc[0];
      acc = acc >> 1;
      fl = fl_of(acc, cy);
      acc_op(OP_SHIFT_RIGHT);
      st();
      x[15] = 1'b0;
      y[15] = 1'b0;
      wr(ADDR_OPERAND, {16'h0000, x});
      wr(ADDR_XY, {16'h0000, y});
      acc = acc + {16'h0000, x} * {16'h0000, y};
      acc_op(OP_MAC);
      cy = acc[31];
      acc = acc << 1;
      fl = fl_of(acc, cy);
      acc_op(OP_SHIFT_LEFT);
      acc = (acc[31:16] >= x) ? 32'({acc[31:16] - x, acc[15:0], 1'b1})
                              : {acc[30:0], 1'b0};
      fl = fl_of(acc, fl[4]);
      acc_op(OP_DIV_STEP);
      sweep();
    end
    $display("test arithmetic done");
    for (int k = 0; k < 2; k++) begin
      v = (k == 0) ? 16'h0080 : {8'h00, 8'(rnd())};
      wr(ADDR_IMM, {16'h0000, v});
      ex(OP_LOAD_BYTE, 4'h0, 4'(k), 1'b0);
      pc = pc + PC_STEP_ONE;
      rc(ADDR_FREG, "byte load", {{24{v[7]}}, v[7:0]}, 32'hFFFF);
    end
    v = 16'(rnd());
    wr(ADDR_IMM, {16'h0000, v});
    ex(OP_LOAD_WORD, 4'h0, 4'h3, 1'b0);
    pc = pc + PC_STEP_TWO;
    rc(ADDR_FREG, "word load", {16'h0000, v}, 32'h0000_FFFF);
    st();
    wr(ADDR_IMM, 32'h0000_0005);
    mem_fetch(8'(v + 16'h0005));
    ex(OP_LOAD_INDEXED, 4'h0, 4'h1, 1'b0);
    pc = pc + PC_STEP_ONE;
    rc(ADDR_STORE, "index address", {16'h0, v + 16'h5}, 32'hFFFF);
    rc(ADDR_FREG, "indexed load", {16'h0, mm_rdata}, 32'hFFFF);
    st();
    $display("test loads done");
    mm_addr <= sp[7:0];
    mm_wdata <= v;
    mm_we <= 1'b1;
    @(posedge aclk);
    mm_we <= 1'b0;
    ex(OP_PUSH, 4'h0, 4'h3, 1'b0);
    sp = sp - 16'h0001;
    pc = pc + PC_STEP_ONE;
    rc(ADDR_STORE, "pushed value", {16'h0000, v}, 32'h0000_FFFF);
    st();
    sp = sp + 16'h0001;
    mem_fetch(sp[7:0]);
    ex(OP_RET_INT, 4'h0, 4'h0, 1'b0);
    pc = v;
    st();
    v = 16'(rnd());
    wr(ADDR_MEM_DATA, 32'(v));
    ex(OP_RET_SUB, 4'h0, 4'h0, 1'b0);
    pc = v;
    st();
    $display("test stack done");
    ex(OP_LOOP, 4'h5, 4'h0, 1'b0);
    pc = pc + PC_STEP_ONE;
    st();
    wr(ADDR_INSTR, {15'h0000, 1'b0, 4'h0, COND_ALWAYS, 3'b000, OP_LOOP});
    repeat (4) @(posedge aclk);
    rc(ADDR_PC, "held counter", {16'h0000, pc}, 32'h0000_FFFF);
    rc(ADDR_STATUS, "loop active", 32'h0002_0000, 32'h0002_0000);
    $display("test loop done");
    stop_test();
  end
endmodule : tb_dsp_instruction_execute
